// ---- verif/acp_conv_model.sv ----
// Converter model: DDR clock and interleaved two-channel data bus
`timescale 1ns/1ps
module acp_conv_model #(
    parameter int W = 10
) (
    output logic         conv_clk,
    output logic [W-1:0] conv_bus,
    input  wire logic    run
);
    logic [W-1:0] cnt;

    // ****************************************************************
    // Source-synchronous output
    // ****************************************************************
    initial begin
        conv_clk = 1'b0;
        conv_bus = '0;
        cnt      = '0;
        #7;
        forever begin
            if (run) begin
                conv_bus = cnt;            // Channel A around rising edge
                #50 conv_clk = 1'b1;
                #50 conv_bus = ~cnt;       // Channel B around falling edge
                #50 conv_clk = 1'b0;
                #50 cnt = cnt + 1'b1;
            end else begin
                // Clock stands still; stale data would hide capture slips
                conv_bus = ~conv_bus;
                #100;
            end
        end
    end
endmodule : acp_conv_model

// ---- verif/tb_adc_ddr_capture_path.sv ----
// Testbench of the capture path: APB status, lock, DDR split and resets
`timescale 1ns/1ps
`include "acp_defs.svh"
module tb_adc_ddr_capture_path;
    localparam int W = 10;
    logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]   paddr = '0;
    logic [31:0]   pwdata = '0, prdata;
    logic          pready, pslverr, irq, lock_flag, dsk_clk, sample_valid, conv_clk;
    logic          ref_rst = 1'b0, smp_rst = 1'b0, acq_en = 1'b0, run = 1'b0, quiet = 1'b1;
    logic [W-1:0]  conv_bus, lane_a, lane_b, prev_a, inv_a;
    logic [3:0]    hist = '0;
    int            failures = 0, n_tests = 0, n_valid = 0, n_pairs = 0;

    always #12.5 pclk = ~pclk;

    acp_capture #(.SAMPLE_WIDTH_PARAM(W), .SAMPLE_PERIOD_NS_PARAM(100)) i_acp_capture (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .reference_domain_reset(ref_rst),
        .sample_domain_reset(smp_rst), .converter_output_clock_in(conv_clk),
        .converter_ddr_bus(conv_bus), .acquisition_enable(acq_en),
        .deskewed_sample_clock(dsk_clk), .sample_clock_lock_flag(lock_flag),
        .sample_lane_a(lane_a), .sample_lane_b(lane_b), .sample_valid(sample_valid));

    acp_conv_model #(.W(W)) i_acp_conv_model (.conv_clk(conv_clk), .conv_bus(conv_bus), .run(run));

    // ****************************************************************
    // Compare, bus and closing tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
        repeat (2) @(posedge pclk);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, '0, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, experr});
    endtask : rd_chk

    task automatic finish_test;
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test

    // ****************************************************************
    // Monitors
    // ****************************************************************
    always @(posedge pclk) begin
        hist <= {hist[2:0], conv_clk};
        if (presetn && (hist == 4'h0 || hist == 4'hf)) begin
            chk({31'h0, dsk_clk}, {31'h0, hist[0]});
        end
        if (quiet) chk({31'h0, sample_valid}, 32'h0);
        if (sample_valid === 1'b1) begin
            n_valid++;
            n_pairs++;
            inv_a = ~lane_a;
            if (n_valid >= 2) chk({22'h0, lane_b}, {22'h0, inv_a});
            if (n_valid >= 3) chk({22'h0, lane_a}, {22'h0, prev_a + 1'b1});
            prev_a = lane_a;
        end
    end

    initial begin
        #200us;
        failures++;
        finish_test();
    end

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({lane_a, lane_b, sample_valid, lock_flag}, '0);
        rd_chk(`ACP_OFF_STATUS, 32'h0, 1'b0);
        rd_chk(`ACP_OFF_MASK, 32'h0, 1'b0);
        rd_chk(12'h020, 32'h0, 1'b1);
        wr(`ACP_OFF_MASK, 32'h3);
        rd_chk(`ACP_OFF_MASK, 32'h3, 1'b0);
        run <= 1'b1;
        repeat (120) @(posedge pclk);
        rd_chk(`ACP_OFF_STATE, 32'h3, 1'b0);
        chk({lock_flag, irq}, 32'h3);
        wr(`ACP_OFF_STATUS, 32'h1);
        rd_chk(`ACP_OFF_STATUS, 32'h0, 1'b0);
        chk({31'h0, irq}, 32'h0);
        // Enable held high for good once the consumer is ready
        quiet = 1'b0; n_valid = 0; acq_en <= 1'b1;
        repeat (400) @(posedge pclk);
        chk({31'h0, n_valid >= 45}, 32'h1);
        rd_chk(`ACP_OFF_STATE, 32'h7, 1'b0);
        smp_rst <= 1'b1;
        repeat (4) @(posedge pclk);
        quiet = 1'b1;
        repeat (8) @(posedge pclk);
        chk({lane_a, lane_b, sample_valid}, '0);
        smp_rst <= 1'b0; quiet = 1'b0; n_valid = 0;
        repeat (100) @(posedge pclk);
        chk({31'h0, n_valid >= 8}, 32'h1);
        n_valid = 0; ref_rst <= 1'b1;
        repeat (5) @(posedge pclk);
        chk({31'h0, lock_flag}, 32'h0);
        ref_rst <= 1'b0;
        repeat (120) @(posedge pclk);
        n_valid = 0;
        chk({31'h0, lock_flag}, 32'h1);
        wr(`ACP_OFF_STATUS, 32'h3);
        // Loss of the converter clock drops lock, raises an event, stops pairs
        run <= 1'b0;
        repeat (40) @(posedge pclk);
        quiet = 1'b1;
        chk({lock_flag, irq}, 32'h1);
        rd_chk(`ACP_OFF_STATUS, 32'h2, 1'b0);
        wr(`ACP_OFF_MASK, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(`ACP_OFF_STATUS, 32'h2);
        rd_chk(`ACP_OFF_STATUS, 32'h0, 1'b0);
        rd_chk(`ACP_OFF_PAIRS, n_pairs, 1'b0);
        repeat (50) @(posedge pclk);
        finish_test();
    end
endmodule : tb_adc_ddr_capture_path

// ---- verilog/acp_capture.sv ----
// Capture path: converter clock tracking, DDR split, lock flag, APB status
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "acp_defs.svh"

module acp_capture #(
    parameter int SAMPLE_WIDTH_PARAM     = 14,
    parameter int SAMPLE_PERIOD_NS_PARAM = 100
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output      logic [31:0]                   prdata,
    output      logic                          pready,
    output      logic                          pslverr,
    output      logic                          irq,
    input  wire logic                          reference_domain_reset,
    input  wire logic                          sample_domain_reset,
    input  wire logic                          converter_output_clock_in,
    input  wire logic [SAMPLE_WIDTH_PARAM-1:0] converter_ddr_bus,
    input  wire logic                          acquisition_enable,
    output      logic                          deskewed_sample_clock,
    output      logic                          sample_clock_lock_flag,
    output      logic [SAMPLE_WIDTH_PARAM-1:0] sample_lane_a,
    output      logic [SAMPLE_WIDTH_PARAM-1:0] sample_lane_b,
    output      logic                          sample_valid
);
    import acp_pkg::*;

    localparam int W        = SAMPLE_WIDTH_PARAM;
    localparam int LOSS_NS  = `ACP_LOSS_PERIODS * SAMPLE_PERIOD_NS_PARAM;
    localparam int LOSS_CYC = (LOSS_NS + `ACP_CLK_PERIOD_NS - 1) / `ACP_CLK_PERIOD_NS;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    generate
        if (SAMPLE_PERIOD_NS_PARAM > `ACP_PERIOD_MAX_NS ||
            SAMPLE_PERIOD_NS_PARAM < 1) begin : g_bad_period
            $error("sample period out of range");
        end
        if (W < `ACP_WIDTH_MIN || W > `ACP_WIDTH_MAX) begin : g_bad_width
            $error("sample width out of range");
        end
        if (LOSS_CYC < 2 || LOSS_CYC > 255) begin : g_bad_loss
            $error("loss timeout does not fit");
        end
    endgenerate

    typedef struct packed {
        logic                     clk_s1;
        logic                     clk_s2;
        logic                     clk_s3;
        logic [W-1:0]             bus_s1;
        logic [W-1:0]             bus_s2;
        logic                     en_s1;
        logic                     en_s2;
        logic                     rrst_s1;
        logic                     rrst_s2;
        logic                     srst_s1;
        logic                     srst_s2;
        acp_lock_t                lock;
        logic [7:0]               gap_cnt;
        logic [3:0]               edge_cnt;
        logic [W-1:0]             hold_a;
        logic [W-1:0]             lane_a;
        logic [W-1:0]             lane_b;
        logic                     valid;
        logic                     lock_r1;
        logic                     lock_r2;
        logic [`ACP_EV_BITS-1:0]  status;
        logic [`ACP_EV_BITS-1:0]  mask;
        logic [15:0]              pairs;
        logic                     ack;
        logic [31:0]              rdata;
        logic                     slverr;
    } acp_state_t;

    acp_state_t st_ff;
    acp_state_t nxt_st;

    logic                    rise;
    logic                    fall;
    logic                    acquire;
    logic                    take;
    logic                    done;
    logic [`ACP_EV_BITS-1:0] ev_set;
    logic [`ACP_EV_BITS-1:0] w1c;

    assign rise    = st_ff.clk_s2 & ~st_ff.clk_s3;
    assign fall    = ~st_ff.clk_s2 & st_ff.clk_s3;
    // Stray enable drops are obeyed, though the controller should never lower it
    assign acquire = st_ff.en_s2 & (st_ff.lock == ACP_LOCKED) & ~st_ff.srst_s2;
    assign take    = psel & penable & ~st_ff.ack;
    assign done    = psel & penable & st_ff.ack;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_st = st_ff;
        ev_set = '0;
        w1c    = '0;
        // Every converter, enable and domain reset input crosses two flops before use
        nxt_st.clk_s1  = converter_output_clock_in;
        nxt_st.clk_s2  = st_ff.clk_s1;
        nxt_st.clk_s3  = st_ff.clk_s2;
        nxt_st.bus_s1  = converter_ddr_bus;
        nxt_st.bus_s2  = st_ff.bus_s1;
        nxt_st.en_s1   = acquisition_enable;
        nxt_st.en_s2   = st_ff.en_s1;
        nxt_st.rrst_s1 = reference_domain_reset;
        nxt_st.rrst_s2 = st_ff.rrst_s1;
        nxt_st.srst_s1 = sample_domain_reset;
        nxt_st.srst_s2 = st_ff.srst_s1;

        // Lock tracking; gap saturates so a dead clock cannot wrap into lock
        if (rise) begin
            nxt_st.gap_cnt = 8'h00;
        end else if (st_ff.gap_cnt != 8'(LOSS_CYC)) begin
            nxt_st.gap_cnt = st_ff.gap_cnt + 8'h01;
        end
        case (st_ff.lock)
            ACP_UNLOCKED: begin
                if (st_ff.gap_cnt == 8'(LOSS_CYC)) begin
                    nxt_st.edge_cnt = 4'h0;
                end else if (rise) begin
                    nxt_st.edge_cnt = st_ff.edge_cnt + 4'h1;
                    if (st_ff.edge_cnt + 4'h1 == `ACP_LOCK_EDGES) begin
                        nxt_st.lock = ACP_LOCKED;
                        ev_set[`ACP_EV_LOCK_GAINED] = 1'b1;
                    end
                end
            end
            ACP_LOCKED: begin
                if (st_ff.gap_cnt == 8'(LOSS_CYC)) begin
                    nxt_st.lock     = ACP_UNLOCKED;
                    nxt_st.edge_cnt = 4'h0;
                    ev_set[`ACP_EV_LOCK_LOST] = 1'b1;
                end
            end
            default: begin
                nxt_st.lock = ACP_UNLOCKED;
            end
        endcase

        // Lock flag retimed on the reference side, cleared by its reset
        if (st_ff.rrst_s2) begin
            nxt_st.lock_r1 = 1'b0;
            nxt_st.lock_r2 = 1'b0;
        end else begin
            nxt_st.lock_r1 = (st_ff.lock == ACP_LOCKED);
            nxt_st.lock_r2 = st_ff.lock_r1;
        end

        // DDR split: lane A held at rise, pair released at fall
        nxt_st.valid = 1'b0;
        if (st_ff.srst_s2) begin
            nxt_st.hold_a = '0;
            nxt_st.lane_a = '0;
            nxt_st.lane_b = '0;
        end else if (acquire) begin
            if (rise) begin
                nxt_st.hold_a = st_ff.bus_s2;
            end
            if (fall) begin
                nxt_st.lane_a = st_ff.hold_a;
                nxt_st.lane_b = st_ff.bus_s2;
                nxt_st.valid  = 1'b1;
                nxt_st.pairs  = st_ff.pairs + 16'h0001;
            end
        end

        // APB slave, one wait state so read data comes from a flop
        nxt_st.ack = take;
        if (take) begin
            nxt_st.slverr = 1'b0;
            nxt_st.rdata  = 32'h0000_0000;
            case (paddr)
                `ACP_OFF_STATUS: nxt_st.rdata[`ACP_EV_BITS-1:0] = st_ff.status;
                `ACP_OFF_MASK:   nxt_st.rdata[`ACP_EV_BITS-1:0] = st_ff.mask;
                `ACP_OFF_STATE: begin
                    nxt_st.rdata[`ACP_ST_LOCKED]    = (st_ff.lock == ACP_LOCKED);
                    nxt_st.rdata[`ACP_ST_LOCK_FLAG] = st_ff.lock_r2;
                    nxt_st.rdata[`ACP_ST_ACQ_EN]    = st_ff.en_s2;
                end
                `ACP_OFF_PAIRS:  nxt_st.rdata[15:0] = st_ff.pairs;
                `ACP_OFF_LANES: begin
                    nxt_st.rdata[W-1:0]     = st_ff.lane_a;
                    nxt_st.rdata[16+W-1:16] = st_ff.lane_b;
                end
                default:         nxt_st.slverr = 1'b1;
            endcase
        end
        if (done && pwrite) begin
            case (paddr)
                `ACP_OFF_STATUS: w1c         = pwdata[`ACP_EV_BITS-1:0];
                `ACP_OFF_MASK:   nxt_st.mask = pwdata[`ACP_EV_BITS-1:0];
                default: begin
                end
            endcase
        end
        // A new event beats a clear in the same cycle
        nxt_st.status = (st_ff.status & ~w1c) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff        <= '0;
            st_ff.lock   <= ACP_UNLOCKED;
            st_ff.status <= `ACP_RST_STATUS;
            st_ff.mask   <= `ACP_RST_MASK;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata                 = st_ff.rdata;
    assign pready                 = st_ff.ack;
    assign pslverr                = st_ff.slverr & st_ff.ack;
    assign irq                    = |(st_ff.status & st_ff.mask);
    assign deskewed_sample_clock  = st_ff.clk_s3;
    assign sample_clock_lock_flag = st_ff.lock_r2;
    assign sample_lane_a          = st_ff.lane_a;
    assign sample_lane_b          = st_ff.lane_b;
    assign sample_valid           = st_ff.valid;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_pair_edge;
        fall && acquire;
    endsequence
    sequence s_pair_out;
        sample_valid && sample_lane_b == $past(st_ff.bus_s2)
            && sample_lane_a == $past(st_ff.hold_a);
    endsequence

    a_pair_capture: assert property (s_pair_edge |=> s_pair_out)
        else $error("pair not captured at falling edge");
    a_valid_cause: assert property (sample_valid |-> $past(acquire) && $past(fall))
        else $error("valid without enable, lock and reset release");
    a_valid_single: assert property (sample_valid |=> !sample_valid)
        else $error("valid longer than one cycle");
    a_srst_clears: assert property (st_ff.srst_s2 |=> !sample_valid
        && sample_lane_a == '0 && sample_lane_b == '0)
        else $error("lanes not cleared in sample reset");
    a_enable_gate: assert property (!st_ff.en_s2 |=> !sample_valid)
        else $error("valid while enable low");
    a_loss_detect: assert property (st_ff.lock == ACP_LOCKED && !rise [*8]
        |-> ##[0:255] st_ff.lock == ACP_UNLOCKED || rise)
        else $error("clock loss not seen");
    a_flag_delay: assert property ($rose(sample_clock_lock_flag) |-> $past(st_ff.lock == ACP_LOCKED, 2))
        else $error("lock flag not two stages behind lock");
    a_rref_clears: assert property (st_ff.rrst_s2 |=> ##1 !sample_clock_lock_flag)
        else $error("lock flag survives reference reset");
    a_clock_follow: assert property (rise |-> !deskewed_sample_clock ##1 deskewed_sample_clock)
        else $error("sample clock out does not follow");
    a_lost_event: assert property (st_ff.lock == ACP_LOCKED ##1
        st_ff.lock == ACP_UNLOCKED |=> st_ff.status[`ACP_EV_LOCK_LOST])
        else $error("lock loss not recorded");
    a_apb_ready: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after one wait state");

    // Lock may only be gained on a seen converter edge, never by timeout wrap
    a_lock_on_edge: assert property ($rose(st_ff.lock == ACP_LOCKED) |-> $past(rise))
        else $error("lock gained without a converter edge");
    // Gain event lands with the lock itself, so software never misses it
    a_gain_event: assert property ($rose(st_ff.lock == ACP_LOCKED)
        |-> st_ff.status[`ACP_EV_LOCK_GAINED])
        else $error("lock gain not recorded");
    // Lanes hold between pairs so a slow consumer still sees one pair
    a_lane_hold: assert property (!st_ff.srst_s2 && !(fall && acquire)
        |=> $stable(sample_lane_a) && $stable(sample_lane_b))
        else $error("lanes changed without a pair");
    a_pair_count: assert property (sample_valid
        |-> st_ff.pairs == $past(st_ff.pairs) + 16'h0001)
        else $error("pair counter out of step with valid");

endmodule : acp_capture

// ---- verilog/acp_defs.svh ----
// Offsets, field positions, reset values and timing counts of the capture path
`ifndef ACP_DEFS_SVH
`define ACP_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACP_OFF_STATUS      12'h000
`define ACP_OFF_MASK        12'h004
`define ACP_OFF_STATE       12'h008
`define ACP_OFF_PAIRS       12'h00c
`define ACP_OFF_LANES       12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define ACP_EV_LOCK_GAINED  0
`define ACP_EV_LOCK_LOST    1
`define ACP_EV_BITS         2
`define ACP_ST_LOCKED       0
`define ACP_ST_LOCK_FLAG    1
`define ACP_ST_ACQ_EN       2

// ****************************************************************
// Reset values
// ****************************************************************
`define ACP_RST_STATUS      2'h0
`define ACP_RST_MASK        2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define ACP_CLK_PERIOD_NS   25
`define ACP_LOSS_PERIODS    4
`define ACP_LOCK_EDGES      4'h8
`define ACP_PERIOD_MAX_NS   100
`define ACP_WIDTH_MIN       10
`define ACP_WIDTH_MAX       16

`endif

// ---- verilog/acp_pkg.sv ----
// Types shared by the capture path
package acp_pkg;

    typedef enum logic [0:0] {
        ACP_UNLOCKED,
        ACP_LOCKED
    } acp_lock_t;

endpackage : acp_pkg
